/* File: hw/capture_cfg_regs.sv */
// register bank and gate control for the four capture channels
// ==========================================
// Notes on behaviour
// - threshold code picks -64 to -82 dB; codes 110 and 111 reserved.
// - boost raises the pair's gate threshold by 30 dB.
// - debounce is 50, 100, 150 or 200 time bases of 6144*scale clocks.
// - per-channel gate enables are ignored when ganged gating is set.
// - ganged gating mutes both channels only when both are quiet long enough.
// - gate mute is soft-ramped or abrupt as the soft-ramp select says.
// - preamp code 00 bypass, 01 +10 dB, 10 +20 dB, 11 reserved.
// - amp code signed half-dB, clamped to +12 dB and -6 dB.
// - digital gain signed 1 dB, clamped at +12 dB, below -96 dB mutes.
// - channel power-off bit downs that channel's front end and decimator.
// - mic clock power-off gates the mic clock, set at reset.
// - mic clock divide picks 64 or 32 times the sample rate.
// - notch-off bypasses the notch filter of the second pair.
// - polarity flip negates that channel's signal when set.
// - digital lift adds fixed +20 dB to that channel when set.
// - highpass corner codes 00, 01, 11 give three corner frequencies.
// - eight mask bits, all set at reset, block interrupt sources.
// - status flags are read-only and sticky; clipping sets overflow flags.
`timescale 1ns/1ps
module capture_cfg_regs #(
  parameter int TIME_BASE = capture_cfg_pkg::TIME_BASE_CLKS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control port, one byte per access
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  // global settings from elsewhere
  input wire logic soft_ramp_select_in,
  input wire logic [2:0] clock_scale_in,
  // signal levels in dB below full scale, both pairs
  input capture_cfg_pkg::chan_levels_t pair1_levels_in,
  input capture_cfg_pkg::chan_levels_t pair2_levels_in,
  // interrupt source events
  input wire logic [7:0] event_in,
  output capture_cfg_pkg::pair2_ctl_t pair2_ctl_out,
  output capture_cfg_pkg::chan_gain_t [3:0] chan_gain_out,
  output logic [3:0] vol_mute_out,
  output logic [3:0] gate_mute_out,
  output logic gate_soft_out,
  output logic irq_out
);
  // ==========================================
  // register storage
  logic [7:0] afe [4];
  logic [7:0] vol [4];
  logic [7:0] ctl1, ctl2, ctl3, gate2, mask, status;
  logic [7:0] p1_ctl3, p1_gate;
  logic [7:0] next_afe [4];
  logic [7:0] next_vol [4];
  logic [7:0] next_ctl1, next_ctl2, next_ctl3, next_gate2, next_mask, next_status;
  logic [7:0] next_rdata;
  logic next_rvalid;
  // first pair gate setup has no offset here; held at reset value
  assign p1_ctl3 = capture_cfg_pkg::RST_CTL3;
  assign p1_gate = capture_cfg_pkg::RST_ZERO;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_afe[i] = afe[i];
      next_vol[i] = vol[i];
    end
    next_ctl1 = ctl1;
    next_ctl2 = ctl2;
    next_ctl3 = ctl3;
    next_gate2 = gate2;
    next_mask = mask;
    // sticky flags, set wins and nothing clears them from the bus
    next_status = status | event_in;
    if (wr_en_in) begin
      unique case (addr_in)
        capture_cfg_pkg::OFF_P1A_AFE: next_afe[0] = wdata_in;
        capture_cfg_pkg::OFF_P1B_AFE: next_afe[1] = wdata_in;
        capture_cfg_pkg::OFF_P2A_AFE: next_afe[2] = wdata_in;
        capture_cfg_pkg::OFF_P2B_AFE: next_afe[3] = wdata_in;
        capture_cfg_pkg::OFF_P1A_VOL: next_vol[0] = wdata_in;
        capture_cfg_pkg::OFF_P1B_VOL: next_vol[1] = wdata_in;
        capture_cfg_pkg::OFF_P2A_VOL: next_vol[2] = wdata_in;
        capture_cfg_pkg::OFF_P2B_VOL: next_vol[3] = wdata_in;
        capture_cfg_pkg::OFF_P2_CTL1: next_ctl1 = wdata_in & capture_cfg_pkg::WM_CTL1;
        capture_cfg_pkg::OFF_P2_CTL2: next_ctl2 = wdata_in & capture_cfg_pkg::WM_CTL2;
        capture_cfg_pkg::OFF_P2_CTL3: begin
          // highpass enable only takes while both channels are powered off
          next_ctl3 = wdata_in & capture_cfg_pkg::WM_CTL3;
          if (!(ctl1[7] && ctl1[6])) begin
            next_ctl3[3] = ctl3[3];
          end
        end
        capture_cfg_pkg::OFF_P2_GATE: begin
          next_gate2 = wdata_in;
          if (wdata_in[4:2] >= capture_cfg_pkg::THR_RSV) begin
            next_gate2[4:2] = gate2[4:2];
          end
        end
        capture_cfg_pkg::OFF_MASK: next_mask = wdata_in;
        default: ;
      endcase
    end
    next_rvalid = rd_en_in;
    next_rdata = 8'h00;
    if (rd_en_in) begin
      unique case (addr_in)
        capture_cfg_pkg::OFF_P1A_AFE: next_rdata = afe[0];
        capture_cfg_pkg::OFF_P1B_AFE: next_rdata = afe[1];
        capture_cfg_pkg::OFF_P2A_AFE: next_rdata = afe[2];
        capture_cfg_pkg::OFF_P2B_AFE: next_rdata = afe[3];
        capture_cfg_pkg::OFF_P1A_VOL: next_rdata = vol[0];
        capture_cfg_pkg::OFF_P1B_VOL: next_rdata = vol[1];
        capture_cfg_pkg::OFF_P2A_VOL: next_rdata = vol[2];
        capture_cfg_pkg::OFF_P2B_VOL: next_rdata = vol[3];
        capture_cfg_pkg::OFF_P2_CTL1: next_rdata = ctl1;
        capture_cfg_pkg::OFF_P2_CTL2: next_rdata = ctl2;
        capture_cfg_pkg::OFF_P2_CTL3: next_rdata = ctl3;
        capture_cfg_pkg::OFF_P2_GATE: next_rdata = gate2;
        capture_cfg_pkg::OFF_MASK: next_rdata = mask;
        capture_cfg_pkg::OFF_STATUS: next_rdata = status;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        afe[i] <= capture_cfg_pkg::RST_ZERO;
        vol[i] <= capture_cfg_pkg::RST_ZERO;
      end
      ctl1 <= capture_cfg_pkg::RST_CTL1;
      ctl2 <= capture_cfg_pkg::RST_ZERO;
      ctl3 <= capture_cfg_pkg::RST_CTL3;
      gate2 <= capture_cfg_pkg::RST_ZERO;
      mask <= capture_cfg_pkg::RST_MASK;
      status <= capture_cfg_pkg::RST_ZERO;
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        afe[i] <= next_afe[i];
        vol[i] <= next_vol[i];
      end
      ctl1 <= next_ctl1;
      ctl2 <= next_ctl2;
      ctl3 <= next_ctl3;
      gate2 <= next_gate2;
      mask <= next_mask;
      status <= next_status;
      rdata_out <= next_rdata;
      rvalid_out <= next_rvalid;
    end
  end

  // ==========================================
  // gain clamps per channel
  capture_cfg_pkg::chan_gain_t gain_c [4];
  logic [3:0] vmute_c;
  for (genvar g = 0; g < 4; g++) begin : g_gain
    gain_clamp u_clamp (
      .afe_in(afe[g]),
      .vol_in(vol[g]),
      .gain_out(gain_c[g]),
      .mute_out(vmute_c[g])
    );
  end

  // ==========================================
  // noise gate, both pairs
  logic [3:0] quiet, chan_en, expired;
  logic [1:0] ganged;
  logic [7:0] thr1, thr2;
  logic [7:0] levels [4];
  logic [1:0] delay [4];
  always_comb begin
    thr1 = capture_cfg_pkg::gate_level_db(p1_gate[4:2], p1_gate[5]);
    thr2 = capture_cfg_pkg::gate_level_db(gate2[4:2], gate2[5]);
    levels[0] = pair1_levels_in.level_a;
    levels[1] = pair1_levels_in.level_b;
    levels[2] = pair2_levels_in.level_a;
    levels[3] = pair2_levels_in.level_b;
    ganged = {ctl3[0], p1_ctl3[0]};
    // larger attenuation means quieter
    quiet[0] = levels[0] > thr1;
    quiet[1] = levels[1] > thr1;
    quiet[2] = levels[2] > thr2;
    quiet[3] = levels[3] > thr2;
    // enable bit 6 serves channel A and bit 7 channel B; index order is 1A 1B 2A 2B
    chan_en = {gate2[7], gate2[6], p1_gate[7], p1_gate[6]};
    for (int i = 0; i < 4; i++) begin
      delay[i] = (i < 2) ? p1_gate[1:0] : gate2[1:0];
    end
  end
  for (genvar g = 0; g < 4; g++) begin : g_gate
    gate_debounce #(.TIME_BASE(TIME_BASE)) u_deb (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .quiet_in(quiet[g]),
      .delay_in(delay[g]),
      .scale_in(clock_scale_in),
      .expired_out(expired[g])
    );
  end
  logic [3:0] next_gate_mute;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (ganged[p]) begin
        // enables ignored, both quiet long enough mutes both
        next_gate_mute[2*p] = expired[2*p] && expired[2*p+1];
        next_gate_mute[2*p+1] = expired[2*p] && expired[2*p+1];
      end else begin
        next_gate_mute[2*p] = chan_en[2*p] && expired[2*p];
        next_gate_mute[2*p+1] = chan_en[2*p+1] && expired[2*p+1];
      end
    end
  end

  // ==========================================
  // registered outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pair2_ctl_out <= '0;
      chan_gain_out <= '0;
      vol_mute_out <= 4'h0;
      gate_mute_out <= 4'h0;
      gate_soft_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      pair2_ctl_out.power_off_a <= ctl1[6];
      pair2_ctl_out.power_off_b <= ctl1[7];
      pair2_ctl_out.clock_off <= ctl1[2];
      pair2_ctl_out.clock_divide <= ctl1[1];
      pair2_ctl_out.notch_off <= ctl2[7];
      pair2_ctl_out.flip_a <= ctl2[4];
      pair2_ctl_out.flip_b <= ctl2[5];
      pair2_ctl_out.lift_a <= ctl2[0];
      pair2_ctl_out.lift_b <= ctl2[1];
      pair2_ctl_out.highpass_on <= ctl3[3];
      // reserved corner code falls back to the lowest corner
      pair2_ctl_out.highpass_corner <= (ctl3[2:1] == capture_cfg_pkg::HPF_RSV) ?
                                       2'h0 : ctl3[2:1];
      for (int i = 0; i < 4; i++) begin
        chan_gain_out[i] <= gain_c[i];
      end
      vol_mute_out <= vmute_c;
      gate_mute_out <= next_gate_mute;
      gate_soft_out <= soft_ramp_select_in;
      irq_out <= |(status & ~mask);
    end
  end

  // ==========================================
  // checks
  // gate checks watch pair two, the only pair whose gate setup is writable here
  a_irq_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ##1 irq_out == |($past(status) & ~$past(mask))) else $error("irq mismatch");
  a_status_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (status != 8'h00) |=> ((status & $past(status)) == $past(status)))
    else $error("status flag dropped");
  a_event_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    event_in[3] |=> status[3]) else $error("event lost");
  a_status_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_en_in && addr_in == 8'h36) |=> rdata_out == $past(status))
    else $error("status read");
  a_mask_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_en_in && addr_in == 8'h35) |=> mask == $past(wdata_in)) else $error("mask write");
  a_thr_reserved: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ##1 gate2[4:2] < 3'h6) else $error("reserved threshold stored");
  a_hpf_guard: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!(ctl1[7] && ctl1[6])) |=> ctl3[3] == $past(ctl3[3])) else $error("hpf changed");
  a_boost_raise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (gate2[5] && gate2[4:2] == 3'h0 && pair2_levels_in.level_a > 8'h22 &&
    pair2_levels_in.level_a <= 8'h40) |-> quiet[2]) else $error("boost ignored");
  a_gate_disabled: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!ctl3[0] && !gate2[6]) |=> !gate_mute_out[2]) else $error("disabled gate muted");
  a_gate_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !quiet[2] |-> ##2 !gate_mute_out[2]) else $error("gate not released");
  a_gang_both: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ctl3[0] && !expired[2]) |=> !gate_mute_out[3]) else $error("ganged mute one");
  a_gang_enables: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ctl3[0] && expired[2] && expired[3]) |=> (gate_mute_out[2] && gate_mute_out[3]))
    else $error("ganged mute missing");
  a_amp_top: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (afe[2][5:0] == 6'h1F) |=> chan_gain_out[2].amp_gain == 6'h18) else $error("amp clamp");
  a_vol_mute: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (vol[3] >= 8'h80 && vol[3] <= 8'h9F) |=> vol_mute_out[3]) else $error("vol mute");
  a_notch_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ##1 pair2_ctl_out.notch_off == $past(ctl2[7])) else $error("notch");
  a_clock_divide: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ##1 pair2_ctl_out.clock_divide == $past(ctl1[1])) else $error("mic clock divide");
  a_flip_b: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ##1 pair2_ctl_out.flip_b == $past(ctl2[5])) else $error("polarity flip");
  // ==========================================
  // cover points
  c_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(irq_out));
  c_gate_mute: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(gate_mute_out[2]));
  c_gang: cover property (@(posedge clk_in) disable iff (!rst_n_in) ctl3[0] && gate_mute_out[3]);
  c_boost_mute: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    gate2[5] && gate_mute_out[2]);
  c_hpf_off: cover property (@(posedge clk_in) disable iff (!rst_n_in) $fell(ctl3[3]));
endmodule // capture_cfg_regs

/* File: hw/capture_cfg_pkg.sv */
// shared constants and types for the capture path configuration registers
package capture_cfg_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFF_P1A_AFE = 8'h29;
  localparam logic [7:0] OFF_P1B_AFE = 8'h2A;
  localparam logic [7:0] OFF_P1A_VOL = 8'h2B;
  localparam logic [7:0] OFF_P1B_VOL = 8'h2C;
  localparam logic [7:0] OFF_P2_CTL1 = 8'h2D;
  localparam logic [7:0] OFF_P2_CTL2 = 8'h2E;
  localparam logic [7:0] OFF_P2_CTL3 = 8'h2F;
  localparam logic [7:0] OFF_P2_GATE = 8'h30;
  localparam logic [7:0] OFF_P2A_AFE = 8'h31;
  localparam logic [7:0] OFF_P2B_AFE = 8'h32;
  localparam logic [7:0] OFF_P2A_VOL = 8'h33;
  localparam logic [7:0] OFF_P2B_VOL = 8'h34;
  localparam logic [7:0] OFF_MASK = 8'h35;
  localparam logic [7:0] OFF_STATUS = 8'h36;
  // ==========================================
  // reset values and writable bits
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h04;
  localparam logic [7:0] RST_CTL3 = 8'h08;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] WM_CTL1 = 8'hC6;
  localparam logic [7:0] WM_CTL2 = 8'hB3;
  localparam logic [7:0] WM_CTL3 = 8'h0F;
  // ==========================================
  // field codes
  localparam logic [2:0] THR_RSV = 3'h6;
  localparam logic [1:0] PRE_RSV = 2'h3;
  localparam logic [5:0] AMP_TOP = 6'h18;
  localparam logic [5:0] AMP_BOT = 6'h34;
  localparam logic [7:0] VOL_TOP = 8'h0C;
  localparam logic [7:0] VOL_BOT = 8'hA0;
  localparam logic [1:0] HPF_RSV = 2'h2;
  // threshold in dB below full scale per code, boost 30 dB
  localparam int THR_BOOST_DB = 30;
  // debounce: time base counts of 6144 master clocks times scale
  localparam int TIME_BASE_CLKS = 6144;
  localparam int DELAY_STEP = 50;
  // ==========================================
  typedef struct packed {
    logic [7:0] level_a;
    logic [7:0] level_b;
  } chan_levels_t;
  typedef struct packed {
    logic power_off_a;
    logic power_off_b;
    logic clock_off;
    logic clock_divide;
    logic notch_off;
    logic flip_a;
    logic flip_b;
    logic lift_a;
    logic lift_b;
    logic highpass_on;
    logic [1:0] highpass_corner;
  } pair2_ctl_t;
  typedef struct packed {
    logic [1:0] preamp_gain;
    logic [5:0] amp_gain;
    logic [7:0] digital_gain;
  } chan_gain_t;
  // gate threshold attenuation in dB for a code, boost lifts it
  function automatic logic [7:0] gate_level_db(input logic [2:0] code, input logic boost);
    logic [7:0] db;
    unique case (code)
      3'h0: db = 8'd64;
      3'h1: db = 8'd66;
      3'h2: db = 8'd70;
      3'h3: db = 8'd73;
      3'h4: db = 8'd76;
      default: db = 8'd82;
    endcase
    gate_level_db = boost ? db - 8'(THR_BOOST_DB) : db;
  endfunction
endpackage

/* File: hw/gain_clamp.sv */
// clamps one channel's preamp, amp and digital gain codes to the legal range
`timescale 1ns/1ps
module gain_clamp (
  input wire logic [7:0] afe_in,
  input wire logic [7:0] vol_in,
  output capture_cfg_pkg::chan_gain_t gain_out,
  output logic mute_out
);
  // ==========================================
  // clamping
  always_comb begin
    gain_out.preamp_gain = (afe_in[7:6] == capture_cfg_pkg::PRE_RSV) ? 2'h0 : afe_in[7:6];
    // signed amp code: +12 dB top, -6 dB bottom
    if (!afe_in[5] && afe_in[5:0] >= capture_cfg_pkg::AMP_TOP) begin
      gain_out.amp_gain = capture_cfg_pkg::AMP_TOP;
    end else if (afe_in[5] && afe_in[5:0] <= capture_cfg_pkg::AMP_BOT) begin
      gain_out.amp_gain = capture_cfg_pkg::AMP_BOT;
    end else begin
      gain_out.amp_gain = afe_in[5:0];
    end
    mute_out = 1'b0;
    if (!vol_in[7] && vol_in >= capture_cfg_pkg::VOL_TOP) begin
      gain_out.digital_gain = capture_cfg_pkg::VOL_TOP;
    end else if (vol_in[7] && vol_in < capture_cfg_pkg::VOL_BOT) begin
      gain_out.digital_gain = capture_cfg_pkg::VOL_BOT;
      mute_out = 1'b1;
    end else begin
      gain_out.digital_gain = vol_in;
    end
  end
endmodule // gain_clamp

/* File: hw/gate_debounce.sv */
// counts time bases while a gated channel stays quiet, then reports mute
`timescale 1ns/1ps
module gate_debounce #(
  parameter int TIME_BASE = capture_cfg_pkg::TIME_BASE_CLKS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic quiet_in,
  input wire logic [1:0] delay_in,
  input wire logic [2:0] scale_in,
  output logic expired_out
);
  // ==========================================
  // time base and count of time bases
  logic [15:0] tick;
  logic [7:0] bases;
  logic [15:0] next_tick;
  logic [7:0] next_bases;
  logic next_expired;
  logic [15:0] tick_end;
  logic [7:0] bases_end;
  always_comb begin
    tick_end = 16'(TIME_BASE * int'(scale_in) - 1);
    bases_end = 8'(capture_cfg_pkg::DELAY_STEP * (int'(delay_in) + 1));
    next_tick = tick;
    next_bases = bases;
    next_expired = expired_out;
    if (!quiet_in) begin
      // release without debounce
      next_tick = 16'h0000;
      next_bases = 8'h00;
      next_expired = 1'b0;
    end else if (!expired_out) begin
      if (tick >= tick_end) begin
        next_tick = 16'h0000;
        next_bases = bases + 8'h01;
        if (bases + 8'h01 >= bases_end) begin
          next_expired = 1'b1;
        end
      end else begin
        next_tick = tick + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick <= 16'h0000;
      bases <= 8'h00;
      expired_out <= 1'b0;
    end else begin
      tick <= next_tick;
      bases <= next_bases;
      expired_out <= next_expired;
    end
  end
endmodule // gate_debounce

/* File: test/testbench.sv */
// self-checking testbench for the capture path configuration register bank
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // stimulus and observation signals
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic soft_sel = 1'b0;
  logic [2:0] scale = 3'h1;
  capture_cfg_pkg::chan_levels_t lev1 = '0;
  capture_cfg_pkg::chan_levels_t lev2 = '0;
  logic [7:0] events = 8'h00;
  capture_cfg_pkg::pair2_ctl_t p2;
  capture_cfg_pkg::chan_gain_t [3:0] gains;
  logic [3:0] vmute;
  logic [3:0] gmute;
  logic gsoft;
  logic irq;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // small time base keeps the debounce waits short
  localparam int TB = 4;
  always #12.5 clk_in = ~clk_in;
  capture_cfg_regs #(.TIME_BASE(TB)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
    .rdata_out(rdata), .rvalid_out(rvalid), .soft_ramp_select_in(soft_sel),
    .clock_scale_in(scale), .pair1_levels_in(lev1), .pair2_levels_in(lev2),
    .event_in(events), .pair2_ctl_out(p2), .chan_gain_out(gains),
    .vol_mute_out(vmute), .gate_mute_out(gmute), .gate_soft_out(gsoft), .irq_out(irq));
  // ==========================================
  // shared tasks
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr_en <= 1'b0;
    cyc(2);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1;
    chk({7'h00, rvalid, rdata}, {7'h00, 1'b1, exp}, "read data");
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [7:0] e;
    for (int a = 8'h28; a <= 8'h37; a++) begin
      e = (a == 8'h2D) ? 8'h04 : (a == 8'h2F) ? 8'h08 : (a == 8'h35) ? 8'hFF : 8'h00;
      rd(8'(a), e);
    end
    chk(16'(p2), 16'h0204, "reset controls");
    chk({irq, gsoft, gmute, vmute}, 16'h0000, "reset outputs");
    $display("test reset values done");
  endtask
  task automatic t_ctl;
    wr(8'h2D, 8'hFF);
    rd(8'h2D, 8'hC6);
    wr(8'h2D, 8'h40);
    chk({p2.power_off_a, p2.power_off_b, p2.clock_off, p2.clock_divide}, 16'h8, "ctl1 a");
    wr(8'h2D, 8'h86);
    chk({p2.power_off_a, p2.power_off_b, p2.clock_off, p2.clock_divide}, 16'h7, "ctl1 b");
    wr(8'h2E, 8'h12);
    chk({p2.notch_off, p2.flip_a, p2.flip_b, p2.lift_a, p2.lift_b}, 16'h09, "ctl2");
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'hB3);
    chk({p2.notch_off, p2.flip_a, p2.flip_b, p2.lift_a, p2.lift_b}, 16'h1F, "ctl2 all");
    wr(8'h2E, 8'h00);
    wr(8'h2D, 8'h00);
    $display("test control bits done");
  endtask
  task automatic t_hpf;
    // enable change is refused while either channel runs
    wr(8'h2F, 8'h00);
    chk(16'(p2.highpass_on), 16'h1, "hpf powered");
    wr(8'h2D, 8'hC0);
    wr(8'h2F, 8'h04);
    chk({p2.highpass_on, p2.highpass_corner}, 16'h0, "hpf reserved");
    wr(8'h2F, 8'h06);
    chk(16'(p2.highpass_corner), 16'h3, "hpf 11");
    wr(8'h2F, 8'h0A);
    chk({p2.highpass_on, p2.highpass_corner}, 16'h5, "hpf 01");
    wr(8'h2F, 8'h08);
    wr(8'h2D, 8'h00);
    $display("test highpass done");
  endtask
  task automatic t_gain;
    wr(8'h31, 8'hDF);
    chk({gains[2].preamp_gain, gains[2].amp_gain}, 16'h018, "amp top");
    wr(8'h31, 8'h60);
    chk({gains[2].preamp_gain, gains[2].amp_gain}, 16'h074, "amp bottom");
    wr(8'h32, 8'hBA);
    chk({gains[3].preamp_gain, gains[3].amp_gain}, 16'h0BA, "amp mid");
    wr(8'h33, 8'h7F);
    chk({vmute[2], gains[2].digital_gain}, 16'h00C, "vol top");
    wr(8'h33, 8'h0B);
    chk({vmute[2], gains[2].digital_gain}, 16'h00B, "vol 11");
    wr(8'h34, 8'h85);
    chk({vmute[3], gains[3].digital_gain}, 16'h1A0, "vol mute");
    wr(8'h34, 8'hA0);
    chk({vmute[3], gains[3].digital_gain}, 16'h0A0, "vol floor");
    wr(8'h29, 8'h4A);
    chk({gains[0].preamp_gain, gains[0].amp_gain}, 16'h04A, "pair1 a afe");
    wr(8'h2C, 8'h90);
    chk({vmute[1], gains[1].digital_gain}, 16'h1A0, "pair1 b mute");
    $display("test gain clamps done");
  endtask
  task automatic t_gate;
    wr(8'h30, 8'h08);
    wr(8'h30, 8'h18);
    rd(8'h30, 8'h08);
    wr(8'h30, 8'h1C);
    rd(8'h30, 8'h08);
    wr(8'h30, 8'h40);
    @(posedge clk_in);
    lev2 <= '{level_a: 8'd70, level_b: 8'd0};
    cyc(50 * TB - 10);
    chk(16'(gmute), 16'h0, "gate early");
    cyc(20);
    chk(16'(gmute), 16'h4, "gate muted");
    @(posedge clk_in);
    lev2 <= '{level_a: 8'd40, level_b: 8'd0};
    cyc(3);
    chk(16'(gmute), 16'h0, "gate released");
    wr(8'h30, 8'h60);
    cyc(50 * TB + 10);
    chk(16'(gmute), 16'h4, "gate boost");
    @(posedge clk_in);
    soft_sel <= 1'b1;
    cyc(3);
    chk(16'(gsoft), 16'h1, "soft ramp");
    $display("test independent gate done");
  endtask
  task automatic t_gang;
    wr(8'h30, 8'h15);
    wr(8'h2F, 8'h09);
    @(posedge clk_in);
    scale <= 3'h2;
    lev2 <= '{level_a: 8'd90, level_b: 8'd20};
    lev1 <= '{level_a: 8'd90, level_b: 8'd90};
    cyc(850);
    chk(16'(gmute), 16'h0, "gang one quiet");
    @(posedge clk_in);
    lev2 <= '{level_a: 8'd90, level_b: 8'd90};
    cyc(100 * TB * 2 - 10);
    chk(16'(gmute), 16'h0, "gang early");
    cyc(20);
    chk(16'(gmute), 16'hC, "gang muted");
    wr(8'h2F, 8'h08);
    $display("test ganged gate done");
  endtask
  task automatic t_irq;
    @(posedge clk_in);
    events <= 8'h02;
    @(posedge clk_in);
    events <= 8'h00;
    cyc(3);
    chk(16'(irq), 16'h0, "irq masked");
    rd(8'h36, 8'h02);
    wr(8'h35, 8'hFD);
    chk(16'(irq), 16'h1, "irq unmasked");
    rd(8'h35, 8'hFD);
    wr(8'h36, 8'h00);
    rd(8'h36, 8'h02);
    wr(8'h35, 8'hFF);
    chk(16'(irq), 16'h0, "irq remasked");
    @(posedge clk_in);
    events <= 8'h80;
    @(posedge clk_in);
    events <= 8'h00;
    wr(8'h35, 8'h7F);
    chk(16'(irq), 16'h1, "irq shutdown");
    $display("test interrupt mask done");
  endtask
  // ==========================================
  // hang guard and main sequence
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cyc(1);
    t_reset();
    t_ctl();
    t_hpf();
    t_gain();
    t_gate();
    t_gang();
    t_irq();
    report_and_stop();
  end
endmodule // testbench
